/* bench/sdram_powerdown_odt_wl_timing_tb.sv */
// Self-checking bench for the power-down, termination and leveling timing block
`timescale 1ns/1ps
module sdram_powerdown_odt_wl_timing_tb;
  import spowt_pkg::*;
  logic clock, arst_n, run, ck, cke, cs_n, ras_n, cas_n, we_n, bc_n, auto_pre, odt, dqs;
  logic dll_frozen, bc4_fixed, wlevel_en, slow_grade;
  logic [4:0] read_lat, write_lat, wr_cyc;
  logic pd_low, cmd_path_en, dll_cmd_ok, rtt_en, rtt_wr_sel, wl_dq, timing_err;
  int err_count = 0;
  int n_compared = 0;

  spowt_ctrl_model m (.run(run), .ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bc_n(bc_n), .auto_pre(auto_pre), .odt(odt), .dqs(dqs));

  spowt_core DUT (.CLOCK(clock), .ARST_N(arst_n), .CK(ck), .CKE(cke), .CS_N(cs_n), .RAS_N(ras_n),
    .CAS_N(cas_n), .WE_N(we_n), .BC_N(bc_n), .AUTO_PRE(auto_pre), .ODT(odt), .DQS(dqs),
    .DLL_FROZEN(dll_frozen), .BC4_FIXED(bc4_fixed), .WLEVEL_EN(wlevel_en), .SLOW_GRADE(slow_grade),
    .READ_LAT(read_lat), .WRITE_LAT(write_lat), .WR_CYC(wr_cyc), .PD_LOW(pd_low),
    .CMD_PATH_EN(cmd_path_en), .DLL_CMD_OK(dll_cmd_ok), .RTT_EN(rtt_en), .RTT_WR_SEL(rtt_wr_sel),
    .WL_DQ(wl_dq), .TIMING_ERR(timing_err));

  // Block clock and static mode settings
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial
  begin
    {arst_n, run, dll_frozen, bc4_fixed, wlevel_en, slow_grade} = 6'h00;
    read_lat = 5'h06;
    write_lat = 5'h05;
    wr_cyc = 5'h0A;
  end

  task automatic chk(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t %s got %b", $time, what, got);
    end
  endtask

  // Outputs land a few block clocks after the synchronised link edge;
  // the frozen termination path needs three block clocks from the pin
  task automatic settle();
    repeat (4) @(negedge clock);
  endtask

  // Link clock stands still across reset, restarted only after release
  task automatic t_reset();
    run = 1'b0;
    arst_n = 1'b0;
    repeat (10) @(negedge clock);
    chk(pd_low, 1'b0, "reset pd_low");
    chk(cmd_path_en, 1'b1, "reset cmd_path_en");
    chk(dll_cmd_ok, 1'b1, "reset dll_cmd_ok");
    chk(rtt_en, 1'b0, "reset rtt_en");
    chk(rtt_wr_sel, 1'b0, "reset rtt_wr_sel");
    chk(wl_dq, 1'b0, "reset wl_dq");
    chk(timing_err, 1'b0, "reset timing_err");
    arst_n = 1'b1;
    repeat (3) @(negedge clock);
    run = 1'b1;
    m.edges(2);
  endtask

  // Entry one edge after an activate, busy work finished before low power
  task automatic t_power_down();
    m.cmd(4'h3, 1'b1, 1'b0);
    m.cke = 1'b0;
    m.edges(0);
    settle();
    chk(cmd_path_en, 1'b1, "path still open one edge after entry");
    m.edges(5);
    settle();
    chk(cmd_path_en, 1'b0, "path closed in power-down");
    chk(pd_low, 1'b1, "low power after busy work");
    m.cke = 1'b1;
    m.edges(0);
    settle();
    chk(cmd_path_en, 1'b1, "path open after exit");
    chk(pd_low, 1'b0, "left low power");
    chk(timing_err, 1'b0, "legal entry and exit");
    m.edges(3);
  endtask

  // Frozen power-down: termination follows the pin, locked-DLL wait on exit
  task automatic t_frozen();
    dll_frozen = 1'b1;
    m.cke = 1'b0;
    m.edges(3);
    m.odt = 1'b1;
    settle();
    chk(rtt_en, 1'b1, "async termination on");
    m.edges(4);
    m.odt = 1'b0;
    settle();
    chk(rtt_en, 1'b0, "async termination off");
    m.cke = 1'b1;
    m.edges(0);
    settle();
    chk(dll_cmd_ok, 1'b0, "locked-DLL commands held back");
    m.edges(10);
    settle();
    chk(dll_cmd_ok, 1'b1, "locked-DLL commands allowed");
    chk(timing_err, 1'b0, "frozen exit legal");
    dll_frozen = 1'b0;
  endtask

  // Synchronous termination delayed by write latency less two
  task automatic t_termination();
    m.odt = 1'b1;
    m.edges(4);
    m.odt = 1'b0;
    settle();
    chk(rtt_en, 1'b1, "termination on after latency");
    m.edges(6);
    settle();
    chk(rtt_en, 1'b0, "termination off");
    chk(timing_err, 1'b0, "four-edge termination legal");
    // Raised with an eight-beat write: six edges high, write termination selected
    m.edges(0);
    m.odt = 1'b1;
    m.cmd(4'h4, 1'b1, 1'b0);
    m.edges(5);
    m.odt = 1'b0;
    settle();
    chk(rtt_wr_sel, 1'b1, "write termination selected");
    chk(rtt_en, 1'b1, "termination on with write");
    m.edges(6);
    settle();
    chk(rtt_wr_sel, 1'b0, "write termination released");
    chk(rtt_en, 1'b0, "termination off after write");
    chk(timing_err, 1'b0, "six-edge termination with write legal");
  endtask

  // Entry exactly gap edges after a command must pass; then a legal exit
  task automatic pd_after(input logic [3:0] c, input logic bc, input logic ap, input int gap, input string what);
    m.cmd(c, bc, ap);
    if (gap > 1)
      m.edges(gap - 1);
    m.cke = 1'b0;
    m.edges(3);
    m.cke = 1'b1;
    m.edges(3);
    chk(timing_err, 1'b0, what);
  endtask

  // Entry spacing at its legal minimum after read, write and mode set, latencies and chop mode varied
  task automatic t_entry_gaps();
    @(negedge clock);
    read_lat = 5'h08;
    write_lat = 5'h07;
    slow_grade = 1'b1;
    m.edges(0);
    pd_after(4'h5, 1'b1, 1'b0, int'(read_lat) + 4 + 1, "entry at RL+5 after read");
    // Write recovery of 15 ns rounds up to one edge at the 80 ns link clock
    pd_after(4'h4, 1'b1, 1'b0, int'(write_lat) + 4 + 1, "entry after write");
    pd_after(4'h4, 1'b0, 1'b1, int'(write_lat) + 4 + int'(wr_cyc) + 1, "entry after autoprecharge write");
    pd_after(4'h0, 1'b1, 1'b0, int'(MOD_NCK), "entry after mode set");
    bc4_fixed = 1'b1;
    pd_after(4'h4, 1'b1, 1'b0, int'(write_lat) + 2 + 1, "entry after fixed-chop write");
    pd_after(4'h4, 1'b1, 1'b1, int'(write_lat) + 2 + int'(wr_cyc) + 1, "entry after fixed-chop autoprecharge");
    bc4_fixed = 1'b0;
  endtask

  // Leveling: sampled clock level returned for strobes in both phases
  task automatic t_leveling();
    wlevel_en = 1'b1;
    m.edges(41);
    m.strobe(1'b1);
    chk(wl_dq, 1'b1, "leveling sees clock high");
    m.strobe(1'b0);
    chk(wl_dq, 1'b0, "leveling sees clock low");
    chk(timing_err, 1'b0, "leveling strobe legal");
    wlevel_en = 1'b0;
    m.edges(2);
  endtask

  // Entry right after a read is too early and sticks until reset
  task automatic t_violation();
    m.cmd(4'h5, 1'b1, 1'b0);
    m.cke = 1'b0;
    m.edges(3);
    settle();
    chk(timing_err, 1'b1, "early entry after read flagged");
    m.cke = 1'b1;
    m.edges(4);
    chk(timing_err, 1'b1, "flag sticky");
    t_reset();
  endtask

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Run is some 250 link edges, under 30 us; the limit leaves ample margin
  initial
  begin
    #200us;
    err_count++;
    results();
  end

  initial
  begin
    t_reset();
    t_power_down();
    t_frozen();
    t_termination();
    t_leveling();
    t_entry_gaps();
    t_violation();
    results();
  end
endmodule // sdram_powerdown_odt_wl_timing_tb

/* bench/spowt_ctrl_model.sv */
// Controller-side model driving link clock, command, termination and strobe pins
`timescale 1ns/1ps
module spowt_ctrl_model (
  input wire logic run,
  output logic ck,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic bc_n,
  output logic auto_pre,
  output logic odt,
  output logic dqs
);
  // Odd start offset keeps the link clock unrelated in phase to the block clock
  initial
  begin
    {ck, cke, cs_n, ras_n, cas_n, we_n, bc_n, auto_pre, odt, dqs} = 10'h1F8;
    #3.3;
    forever #40 ck = run ? ~ck : 1'b0;
  end

  // Wait whole link edges, then move at a falling edge; spacing counted in edges
  task automatic edges(input int n);
    repeat (n) @(posedge ck);
    @(negedge ck);
  endtask

  // One command for one edge, then deselect with stale lines inverted
  task automatic cmd(input logic [3:0] c, input logic bc, input logic ap);
    {cs_n, ras_n, cas_n, we_n} = c;
    bc_n = bc;
    auto_pre = ap;
    @(negedge ck);
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = ~c[2:0];
    bc_n = ~bc;
    auto_pre = ~ap;
  endtask

  // Strobe rise inside the high or the low phase of the link clock
  task automatic strobe(input logic high_phase);
    if (high_phase)
      @(posedge ck);
    else
      @(negedge ck);
    #20 dqs = 1'b1;
    #60 dqs = 1'b0;
  endtask
endmodule // spowt_ctrl_model

/* pkg/spowt_pkg.sv */
// Constants and types for the power-down, termination and leveling timing block
package spowt_pkg;
  localparam int TCK_PS = 80000;
  localparam int CLK_PS = 10000;
  localparam int CW = 7;
  localparam int PW = 10;
  localparam real T_XP_NS = 6.0;
  localparam real T_XPDLL_NS = 24.0;
  localparam real T_CKE_F_NS = 5.0;
  localparam real T_CKE_S_NS = 5.625;
  localparam real T_WR_NS = 15.0;
  localparam real T_MOD_NS = 15.0;
  localparam real T_REFI_NS = 7800.0;
  localparam real T_AONPD_MAX_NS = 8.5;
  localparam real T_WLO_MAX_NS = 7.5;

  function automatic int ps(real ns);
    return int'(ns * 1000.0);
  endfunction

  // Larger of a cycle count and a rounded-up time
  function automatic int nck(int n, real ns);
    int c;
    c = (ps(ns) + TCK_PS - 1) / TCK_PS;
    return (c > n) ? c : n;
  endfunction

  // Longest time in block clocks, never below one
  function automatic int clk_max(real ns);
    int c;
    c = ps(ns) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [CW-1:0] XP_NCK = CW'(nck(3, T_XP_NS));
  localparam logic [CW-1:0] XPDLL_NCK = CW'(nck(10, T_XPDLL_NS));
  localparam logic [CW-1:0] CKE_F_NCK = CW'(nck(3, T_CKE_F_NS));
  localparam logic [CW-1:0] CKE_S_NCK = CW'(nck(3, T_CKE_S_NS));
  localparam logic [CW-1:0] CMD_PDEN_NCK = 7'h01;
  localparam logic [CW-1:0] RD_PDEN_ADD = 7'h05;
  localparam logic [CW-1:0] WR_PDEN_ADD = 7'h04;
  localparam logic [CW-1:0] WR_PDEN_BC4 = 7'h02;
  localparam logic [CW-1:0] WRAP_ADD = 7'h01;
  localparam logic [CW-1:0] WRNS_NCK = CW'(nck(0, T_WR_NS));
  localparam logic [CW-1:0] MOD_NCK = CW'(nck(12, T_MOD_NS));
  localparam logic [CW-1:0] ODTH4_NCK = 7'h04;
  localparam logic [CW-1:0] ODTH8_NCK = 7'h06;
  localparam logic [CW-1:0] WLMRD_NCK = 7'h28;
  localparam logic [CW-1:0] WLDQSEN_NCK = 7'h19;
  localparam logic [CW-1:0] OP_BUSY_NCK = 7'h04;
  localparam logic [4:0] ODTL_SUB = 5'h03;
  localparam logic [PW-1:0] PD_MAX_NCK = PW'((9 * ps(T_REFI_NS)) / TCK_PS);
  localparam int AONPD_MAX_CLK = clk_max(T_AONPD_MAX_NS);
  localparam int WLO_MAX_CLK = clk_max(T_WLO_MAX_NS);

  // Chip select, row, column and write strobes, all active low
  typedef enum logic [3:0] {
    C_MRS = 4'h0,
    C_REF = 4'h1,
    C_PRE = 4'h2,
    C_ACT = 4'h3,
    C_WR = 4'h4,
    C_RD = 4'h5,
    C_ZQ = 4'h6,
    C_NOP = 4'h7
  } spowt_cmd_t;

  typedef enum logic [1:0] {
    PS_ACTIVE = 2'h0,
    PS_ENTER = 2'h1,
    PS_DRAIN = 2'h3,
    PS_DOWN = 2'h2
  } spowt_pd_t;
endpackage

/* rtl/spowt_core.sv */
// Power-down, termination and write-leveling timing of the memory device
`timescale 1ns/1ps
module spowt_core
  import spowt_pkg::*;
(
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic CK,
  input wire logic CKE,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic BC_N,
  input wire logic AUTO_PRE,
  input wire logic ODT,
  input wire logic DQS,
  input wire logic DLL_FROZEN,
  input wire logic BC4_FIXED,
  input wire logic WLEVEL_EN,
  input wire logic SLOW_GRADE,
  input wire logic [4:0] READ_LAT,
  input wire logic [4:0] WRITE_LAT,
  input wire logic [4:0] WR_CYC,
  output logic PD_LOW,
  output logic CMD_PATH_EN,
  output logic DLL_CMD_OK,
  output logic RTT_EN,
  output logic RTT_WR_SEL,
  output logic WL_DQ,
  output logic TIMING_ERR
);
  localparam int AON_MAX = AONPD_MAX_CLK;
  localparam int WLO_MAX = WLO_MAX_CLK;

  logic [9:0] pin_q, pin_rise, pin_fall;
  logic ck_rise, ck_fall, cke_s, odt_s, dqs_s, bl8, frozen, err_ck;
  logic cmd_ok, is_wr, odt_del, wr_del;
  spowt_cmd_t cmd;
  spowt_pd_t state, next_state;
  logic cke_r, odt_r, wl_seen, off_pend, wr_req;
  logic [CW-1:0] xp_cnt, xpdll_cnt, cke_cnt, pden_cnt, busy_cnt, odt_cnt;
  logic [CW-1:0] wlmrd_cnt, wldqs_cnt, wr_len;
  logic [PW-1:0] pd_len;
  logic [31:0] odt_pipe, wr_pipe;
  logic [4:0] odtl_idx;

  function automatic logic [CW-1:0] sat_dec(input logic [CW-1:0] c);
    return (c == '0) ? c : c - 7'h01;
  endfunction

  // Keep the longer of a running wait and a new one
  function automatic logic [CW-1:0] ld(input logic [CW-1:0] cur, input logic [CW-1:0] n);
    logic [CW-1:0] m;
    m = n - 7'h01;
    return (m > cur) ? m : sat_dec(cur);
  endfunction

  // All pins cross into the block clock together, so they stay aligned
  spowt_sync #(.W(10)) u_sync (
    .clk(CLOCK),
    .arst_n(ARST_N),
    .d({CK, CKE, CS_N, RAS_N, CAS_N, WE_N, BC_N, AUTO_PRE, ODT, DQS}),
    .q(pin_q),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // Pin decode; every cycle limit advances on a real CK edge
  assign ck_rise = pin_rise[9];
  assign ck_fall = pin_fall[9];
  assign cke_s = pin_q[8];
  assign cmd = spowt_cmd_t'(pin_q[7:4]);
  assign odt_s = pin_q[1];
  assign dqs_s = pin_q[0];
  assign bl8 = !BC4_FIXED && pin_q[3];
  assign cmd_ok = (state == PS_ACTIVE || state == PS_ENTER) && !pin_q[7] && cmd != C_NOP;
  assign is_wr = cmd_ok && cmd == C_WR;
  assign frozen = DLL_FROZEN && (state == PS_DRAIN || state == PS_DOWN);
  assign odtl_idx = (WRITE_LAT > ODTL_SUB) ? WRITE_LAT - ODTL_SUB : 5'h00;
  assign odt_del = odt_pipe[odtl_idx];
  assign wr_del = wr_pipe[odtl_idx];

  // Write to entry spacing; fixed chop shortens the base
  assign wr_len = CW'(WRITE_LAT) + (BC4_FIXED ? WR_PDEN_BC4 : WR_PDEN_ADD)
    + (pin_q[2] ? CW'(WR_CYC) + WRAP_ADD : WRNS_NCK);

  // Entry keeps commands for one more edge, then drains busy work
  always_comb
  begin
    next_state = state;
    case (state)
      PS_ACTIVE:
        if (ck_rise && !cke_s)
          next_state = PS_ENTER;
      PS_ENTER:
        if (ck_rise)
          next_state = cke_s ? PS_ACTIVE : (busy_cnt == '0 ? PS_DOWN : PS_DRAIN);
      PS_DRAIN:
        if (ck_rise && cke_s)
          next_state = PS_ACTIVE;
        else if (busy_cnt == '0)
          next_state = PS_DOWN;
      PS_DOWN:
        if (ck_rise && cke_s)
          next_state = PS_ACTIVE;
      default:
        next_state = PS_ACTIVE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      state <= PS_ACTIVE;
    else
      state <= next_state;
  end

  // Exit and pulse-width counters
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      xp_cnt <= '0;
      xpdll_cnt <= '0;
      cke_cnt <= '0;
      cke_r <= 1'b1;
    end
    else if (ck_rise)
    begin
      cke_r <= cke_s;
      xp_cnt <= (state != PS_ACTIVE && cke_s) ? XP_NCK - 7'h01 : sat_dec(xp_cnt);
      if (state != PS_ACTIVE && cke_s && DLL_FROZEN)
        xpdll_cnt <= XPDLL_NCK - 7'h01;
      else
        xpdll_cnt <= sat_dec(xpdll_cnt);
      if (cke_s != cke_r)
        cke_cnt <= (SLOW_GRADE ? CKE_S_NCK : CKE_F_NCK) - 7'h01;
      else
        cke_cnt <= sat_dec(cke_cnt);
    end
  end

  // Entry spacing after each command except ZQ, and internal work in flight
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      pden_cnt <= '0;
      busy_cnt <= '0;
    end
    else if (ck_rise)
    begin
      pden_cnt <= sat_dec(pden_cnt);
      busy_cnt <= sat_dec(busy_cnt);
      if (cmd_ok)
        case (cmd)
          C_ACT, C_PRE, C_REF:
          begin
            pden_cnt <= ld(pden_cnt, CMD_PDEN_NCK);
            busy_cnt <= ld(busy_cnt, OP_BUSY_NCK);
          end
          C_RD:
            pden_cnt <= ld(pden_cnt, CW'(READ_LAT) + RD_PDEN_ADD);
          C_WR:
            pden_cnt <= ld(pden_cnt, wr_len);
          C_MRS:
            pden_cnt <= ld(pden_cnt, MOD_NCK);
          default:
            pden_cnt <= sat_dec(pden_cnt);
        endcase
    end
  end

  // Termination hold time and power-down duration
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      odt_cnt <= '0;
      odt_r <= 1'b0;
      pd_len <= '0;
    end
    else if (ck_rise)
    begin
      odt_r <= odt_s;
      if (odt_s && !odt_r)
        odt_cnt <= (is_wr && bl8 ? ODTH8_NCK : ODTH4_NCK) - 7'h01;
      else
        odt_cnt <= sat_dec(odt_cnt);
      if (state == PS_ACTIVE)
        pd_len <= '0;
      else if (pd_len != '1)
        pd_len <= pd_len + 10'h001;
    end
  end

  // Leveling waits start at the first edge with leveling enabled
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      wl_seen <= 1'b0;
      wlmrd_cnt <= '0;
      wldqs_cnt <= '0;
    end
    else if (!WLEVEL_EN)
      wl_seen <= 1'b0;
    else if (ck_rise)
    begin
      wl_seen <= 1'b1;
      wlmrd_cnt <= wl_seen ? sat_dec(wlmrd_cnt) : WLMRD_NCK - 7'h01;
      wldqs_cnt <= wl_seen ? sat_dec(wldqs_cnt) : WLDQSEN_NCK - 7'h01;
    end
  end

  // Any spacing fault at a CK edge
  assign err_ck = (cke_s != cke_r && cke_cnt != '0)
    | (state == PS_ACTIVE && !cke_s && pden_cnt != '0)
    | (state == PS_ACTIVE && cmd_ok && xp_cnt != '0)
    | (cmd_ok && cmd == C_RD && xpdll_cnt != '0)
    | (odt_s && !odt_r && xpdll_cnt != '0)
    | (state != PS_ACTIVE && pd_len >= PD_MAX_NCK)
    | (odt_r && !odt_s && odt_cnt != '0)
    | (WLEVEL_EN && wl_seen && dqs_s && wldqs_cnt != '0);

  // Sticky until reset: only reinitialization recovers
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      TIMING_ERR <= 1'b0;
    else if ((ck_rise && err_ck) || (pin_rise[0] && WLEVEL_EN && wlmrd_cnt != '0))
      TIMING_ERR <= 1'b1;
  end

  // Termination latency pipes, one slot per CK edge
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      odt_pipe <= '0;
      wr_pipe <= '0;
    end
    else if (ck_rise)
    begin
      odt_pipe <= {odt_pipe[30:0], odt_s};
      wr_pipe <= {wr_pipe[30:0], is_wr};
    end
  end

  // Outside frozen power-down, turn-off lands on the CK falling edge, half a period late
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      RTT_EN <= 1'b0;
      RTT_WR_SEL <= 1'b0;
      off_pend <= 1'b0;
      wr_req <= 1'b0;
    end
    else if (frozen)
    begin
      RTT_EN <= odt_s;
      RTT_WR_SEL <= 1'b0;
      off_pend <= 1'b0;
    end
    else if (ck_rise)
    begin
      if (odt_del)
        RTT_EN <= 1'b1;
      off_pend <= !odt_del && RTT_EN;
      wr_req <= odt_del && (wr_del || wr_req);
    end
    else if (ck_fall)
    begin
      if (off_pend)
        RTT_EN <= 1'b0;
      RTT_WR_SEL <= wr_req;
      off_pend <= 1'b0;
    end
  end

  // Leveling result and status outputs
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      WL_DQ <= 1'b0;
      PD_LOW <= 1'b0;
      CMD_PATH_EN <= 1'b1;
      DLL_CMD_OK <= 1'b1;
    end
    else
    begin
      if (WLEVEL_EN && pin_rise[0])
        WL_DQ <= pin_q[9];
      PD_LOW <= next_state == PS_DOWN;
      CMD_PATH_EN <= next_state == PS_ACTIVE || next_state == PS_ENTER;
      DLL_CMD_OK <= next_state == PS_ACTIVE && xpdll_cnt == '0;
    end
  end

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!ARST_N);

  sequence s_entry;
    ck_rise && state == PS_ACTIVE && !cke_s;
  endsequence

  a_cpded_hold: assert property (s_entry |=> state == PS_ENTER ##1 CMD_PATH_EN)
    else $error("command path dropped at entry");
  a_drain_first: assert property (PD_LOW |-> busy_cnt == '0)
    else $error("low power while work in flight");
  a_xp_wait: assert property (ck_rise && state == PS_ACTIVE && cmd_ok && xp_cnt != '0 |=> TIMING_ERR)
    else $error("early command after exit not flagged");
  a_xpdll_wait: assert property (ck_rise && cmd_ok && cmd == C_RD && xpdll_cnt != '0 |=> TIMING_ERR)
    else $error("early read after frozen exit not flagged");
  a_cke_width: assert property (ck_rise && cke_s != cke_r && cke_cnt != '0 |=> TIMING_ERR)
    else $error("short CKE pulse not flagged");
  a_pden_gap: assert property (s_entry and pden_cnt != '0 |=> TIMING_ERR)
    else $error("early entry not flagged");
  a_err_sticky: assert property ($rose(TIMING_ERR) |=> TIMING_ERR [*8])
    else $error("error flag cleared");
  a_rtt_async: assert property (frozen && $changed(odt_s) ##1 frozen |-> ##[0:AON_MAX] RTT_EN == odt_s)
    else $error("frozen termination late");
  a_rtt_off_fall: assert property ($fell(RTT_EN) && !$past(frozen) |-> $past(ck_fall))
    else $error("termination off away from CK fall");
  a_wl_sample: assert property (WLEVEL_EN && pin_rise[0] |-> ##[1:WLO_MAX] WL_DQ == $past(pin_q[9]))
    else $error("leveling result wrong");
endmodule // spowt_core

/* rtl/spowt_sync.sv */
// Two-stage pin synchroniser with edge detection
`timescale 1ns/1ps
module spowt_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // Edges are taken from the second and third stage only
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign q = s2;
  assign rise = s2 & ~s3;
  assign fall = ~s2 & s3;
endmodule // spowt_sync
